// file: inc/rra_pkg.sv
// rra_pkg: register map, field positions, reset values and carriers for the ring redundancy assist
// assumes a 32-bit apb slave on the switch core clock; ports are numbered 0..NPORT-1
package rra_pkg;
   localparam int NPORT = 7;
   localparam int DUP_ENTRIES = 512;
   localparam int DUP_WAYS = 2;
   localparam int DUP_SETS = DUP_ENTRIES / DUP_WAYS;
   localparam int SET_W = 8;
   localparam int AGE_W = 2;
   // register byte addresses
   localparam logic [11:0] ADDR_RING_CTRL = 12'h610;
   localparam logic [11:0] ADDR_BCN_WINDOW = 12'h61c;
   localparam logic [11:0] ADDR_DUP_CTRL = 12'h644;
   localparam logic [11:0] ADDR_DLR_PORTS = 12'h700;
   localparam logic [11:0] ADDR_HSR_PORTS = 12'h704;
   localparam logic [11:0] ADDR_LUE_CTRL1 = 12'h708;
   localparam logic [11:0] ADDR_LUE_CTRL2 = 12'h70c;
   localparam logic [11:0] ADDR_OWN_MAC_LO = 12'h710;
   localparam logic [11:0] ADDR_OWN_MAC_HI = 12'h714;
   localparam logic [11:0] ADDR_PORT_STP = 12'h718;
   localparam logic [11:0] ADDR_PORT_SAF = 12'h71c;
   localparam logic [11:0] ADDR_RING_STAT = 12'h720;
   localparam logic [11:0] ADDR_DUP_IDX = 12'h724;
   localparam logic [11:0] ADDR_DUP_DATA = 12'h728;
   localparam logic [11:0] ADDR_DUP_ACC = 12'h72c;
   localparam logic [11:0] ADDR_AGE_PERIOD = 12'h730;
   // field positions
   localparam int BIT_BACKUP_SUP = 2;
   localparam int BIT_SELF_FILT_ALL = 6;
   localparam int BIT_DUP_EN = 7;
   localparam int BIT_FLUSH = 0;
   localparam int BIT_STP_LO = 1;
   localparam int BIT_STP_HI = 2;
   localparam int BIT_PORT_SAF = 3;
   localparam int BIT_ACC_WRITE = 0;
   localparam int BIT_ACC_READ = 1;
   // reset values
   localparam logic [31:0] RST_BCN_WINDOW = 32'h0000_0000;
   localparam logic [7:0] RST_STP = 8'h06;
   localparam logic [31:0] RST_AGE_PERIOD = 32'h0100_0000;

   // one duplicate table entry
   typedef struct packed {
      logic valid;
      logic [15:0] seq;
      logic [NPORT-1:0] port;
      logic [AGE_W-1:0] age;
   } rra_dup_entry_t;

   // a frame header presented by the lookup engine
   typedef struct packed {
      logic valid;
      logic [2:0] port;
      logic [47:0] sa;
      logic [47:0] da;
      logic hsr;
      logic [15:0] seq;
      logic host_tagged;
      logic [NPORT-1:0] tail_ports;
   } rra_frame_t;

   // forwarding decision returned per frame
   typedef struct packed {
      logic valid;
      logic drop_self;
      logic drop_dup;
      logic [NPORT-1:0] egress;
   } rra_verdict_t;
endpackage : rra_pkg

// file: design/rra_core.sv
// rra_core: ring redundancy assist for a multi-port switch (dlr backup supervisor, hsr filters)
// assumes apb master on clk, acl engine supplying per-port beacon timeout pulses,
// lookup engine presenting one frame header at a time and flushing on request
//
// Register access over APB was left to the implementer.
module rra_core #(
   parameter int AGE_PERIOD_DEF = 32'h0100_0000
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // beacon timeout pulses from the acl engine, one per port
   input wire logic [rra_pkg::NPORT-1:0] acl_bcn_timeout,
   // frame header in, verdict out
   input rra_pkg::rra_frame_t frame_in,
   output rra_pkg::rra_verdict_t verdict,
   // controls toward the switch fabric
   output logic [rra_pkg::NPORT-1:0] port_blocked,
   output logic flush_req,
   output logic supervisor_lost
);
   import rra_pkg::*;

   typedef struct packed {
      logic [7:0] ring_ctrl;
      logic [31:0] bcn_window;
      logic [7:0] dup_ctrl;
      logic [NPORT-1:0] dlr_ports;
      logic [NPORT-1:0] hsr_ports;
      logic [7:0] lue_ctrl1;
      logic [47:0] own_mac;
      logic [NPORT*8-1:0] stp;
      logic [NPORT-1:0] port_saf;
      logic [SET_W:0] dup_idx;
      logic [31:0] dup_data;
      logic [31:0] age_period;
      logic [31:0] age_cnt;
      logic age_tick;
      logic [31:0] bcn_gap;
      logic first_seen;
      logic first_port;
      logic sup_lost;
      logic flush;
      logic [31:0] rdata;
      logic ready;
      logic err;
      rra_verdict_t verd;
      logic [NPORT-1:0] blocked;
      logic [DUP_SETS-1:0] lru;
   } rra_state_t;

   rra_state_t st_ff;
   rra_state_t nxt_st;
   rra_dup_entry_t dup_mem [0:DUP_ENTRIES-1];

   // hash of sa and da folded to a set index
   function automatic logic [SET_W-1:0] rra_hash(input logic [47:0] sa, input logic [47:0] da);
      logic [95:0] k;
      logic [SET_W-1:0] h;
      k = {sa, da};
      h = '0;
      for (int i = 0; i < 96; i += SET_W) begin
         h = h ^ k[i +: SET_W];
      end
      return h;
   endfunction : rra_hash

   // ring map helpers: index of the lowest set bit of a map, and whether exactly two bits are set
   function automatic logic [2:0] rra_low_bit(input logic [NPORT-1:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = NPORT-1; i >= 0; i--) begin
         if (m[i]) r = 3'(i);
      end
      return r;
   endfunction : rra_low_bit

   function automatic logic rra_two_bits(input logic [NPORT-1:0] m);
      return $countones(m) == 2;
   endfunction : rra_two_bits

   // table lookup, combinational on the presented frame
   logic [SET_W-1:0] set_idx;
   rra_dup_entry_t e0, e1;
   logic hit0, hit1, dup_hit, on_ring, self_hit, saf_on;
   logic [2:0] dlr_a;
   logic [NPORT-1:0] dlr_other;
   always_comb begin
      set_idx = rra_hash(frame_in.sa, frame_in.da);
      e0 = dup_mem[{set_idx, 1'b0}];
      e1 = dup_mem[{set_idx, 1'b1}];
      hit0 = e0.valid && e0.seq == frame_in.seq && e0.port != (NPORT'(1) << frame_in.port);
      hit1 = e1.valid && e1.seq == frame_in.seq && e1.port != (NPORT'(1) << frame_in.port);
      on_ring = rra_two_bits(st_ff.hsr_ports) && st_ff.hsr_ports[frame_in.port];
      dup_hit = st_ff.dup_ctrl[BIT_DUP_EN] && frame_in.hsr && on_ring && (hit0 || hit1);
      saf_on = st_ff.lue_ctrl1[BIT_SELF_FILT_ALL] || st_ff.port_saf[frame_in.port];
      self_hit = saf_on && frame_in.sa == st_ff.own_mac;
      dlr_a = rra_low_bit(st_ff.dlr_ports);
      dlr_other = st_ff.dlr_ports & ~(NPORT'(1) << dlr_a);
   end

   // next state: registers, supervisor watch, verdict, aging
   logic [NPORT-1:0] dlr_to;
   logic acc_wr, acc_rd;
   logic wen;
   logic alloc;
   logic [SET_W:0] alloc_addr;
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ready = 1'b0;
      nxt_st.err = 1'b0;
      nxt_st.flush = 1'b0;
      acc_wr = 1'b0;
      acc_rd = 1'b0;
      // apb: one wait state; read data is captured in the first access cycle, while writes
      // land only at the edge where the master sees pready, so nothing changes unacknowledged
      wen = psel && penable && pwrite && st_ff.ready;
      if (psel && penable) begin
         nxt_st.ready = !st_ff.ready;
         nxt_st.rdata = 32'h0000_0000;
         case (paddr)
            ADDR_RING_CTRL: begin
               if (wen) nxt_st.ring_ctrl = pwdata[7:0];
               nxt_st.rdata = {24'h000000, st_ff.ring_ctrl};
            end
            ADDR_BCN_WINDOW: begin
               if (wen) nxt_st.bcn_window = pwdata;
               nxt_st.rdata = st_ff.bcn_window;
            end
            ADDR_DUP_CTRL: begin
               if (wen) nxt_st.dup_ctrl = pwdata[7:0];
               nxt_st.rdata = {24'h000000, st_ff.dup_ctrl};
            end
            ADDR_DLR_PORTS: begin
               if (wen) nxt_st.dlr_ports = pwdata[NPORT-1:0];
               nxt_st.rdata = 32'(st_ff.dlr_ports);
            end
            ADDR_HSR_PORTS: begin
               if (wen) nxt_st.hsr_ports = pwdata[NPORT-1:0];
               nxt_st.rdata = 32'(st_ff.hsr_ports);
            end
            ADDR_LUE_CTRL1: begin
               if (wen) nxt_st.lue_ctrl1 = pwdata[7:0];
               nxt_st.rdata = {24'h000000, st_ff.lue_ctrl1};
            end
            ADDR_LUE_CTRL2: begin
               if (wen) nxt_st.flush = pwdata[BIT_FLUSH];
               nxt_st.rdata = 32'h0000_0000; // self-clearing command
            end
            ADDR_OWN_MAC_LO: begin
               if (wen) nxt_st.own_mac[31:0] = pwdata; // bytes 0..3
               nxt_st.rdata = st_ff.own_mac[31:0];
            end
            ADDR_OWN_MAC_HI: begin
               if (wen) nxt_st.own_mac[47:32] = pwdata[15:0]; // bytes 4..5
               nxt_st.rdata = {16'h0000, st_ff.own_mac[47:32]};
            end
            ADDR_PORT_STP: begin
               // pwdata[10:8] picks the port, pwdata[7:0] the state byte
               if (wen && pwdata[10:8] < 3'(NPORT)) nxt_st.stp[pwdata[10:8]*8 +: 8] = pwdata[7:0];
               nxt_st.rdata = 32'(st_ff.blocked);
            end
            ADDR_PORT_SAF: begin
               if (wen) nxt_st.port_saf = pwdata[NPORT-1:0];
               nxt_st.rdata = 32'(st_ff.port_saf);
            end
            ADDR_RING_STAT: begin
               nxt_st.rdata = {30'h0, st_ff.first_seen, st_ff.sup_lost};
               if (wen && pwdata[0]) nxt_st.sup_lost = 1'b0;
            end
            ADDR_DUP_IDX: begin
               if (wen) nxt_st.dup_idx = pwdata[SET_W:0];
               nxt_st.rdata = 32'(st_ff.dup_idx);
            end
            ADDR_DUP_DATA: begin
               if (wen) nxt_st.dup_data = pwdata;
               nxt_st.rdata = st_ff.dup_data;
            end
            ADDR_DUP_ACC: begin
               acc_wr = wen && pwdata[BIT_ACC_WRITE];
               acc_rd = wen && pwdata[BIT_ACC_READ];
               if (acc_rd) nxt_st.dup_data = 32'(dup_mem[st_ff.dup_idx]);
            end
            ADDR_AGE_PERIOD: begin
               if (wen) nxt_st.age_period = pwdata;
               nxt_st.rdata = st_ff.age_period;
            end
            default: begin
               nxt_st.err = !st_ff.ready; // unmapped address, flagged with pready only
            end
         endcase
      end
      // port blocking from the stp state bytes
      for (int p = 0; p < NPORT; p++) begin
         nxt_st.blocked[p] = !st_ff.stp[p*8+BIT_STP_LO] && !st_ff.stp[p*8+BIT_STP_HI];
      end
      // backup supervisor: a timeout on one ring port opens a window for the other
      dlr_to = acl_bcn_timeout & st_ff.dlr_ports;
      if (st_ff.ring_ctrl[BIT_BACKUP_SUP] && rra_two_bits(st_ff.dlr_ports)) begin
         if (st_ff.first_seen) begin
            // bcn_gap is the distance in cycles from the first timeout to a pulse seen now
            nxt_st.bcn_gap = st_ff.bcn_gap + 32'h1;
            if ((st_ff.first_port ? dlr_to[dlr_a] : |(dlr_to & dlr_other)) &&
                st_ff.bcn_gap <= st_ff.bcn_window) begin
               nxt_st.sup_lost = 1'b1;
               nxt_st.first_seen = 1'b0;
            end else if (st_ff.bcn_gap >= st_ff.bcn_window) begin
               nxt_st.first_seen = 1'b0; // gap too long, not a real loss
            end
         end else if (dlr_to[dlr_a] && |(dlr_to & dlr_other)) begin
            nxt_st.sup_lost = 1'b1; // both in one cycle
         end else if (|dlr_to) begin
            nxt_st.first_seen = 1'b1;
            nxt_st.first_port = !dlr_to[dlr_a];
            nxt_st.bcn_gap = 32'h1;
         end
      end else begin
         nxt_st.first_seen = 1'b0;
      end
      // age tick: periodic sweep advances entry ages
      nxt_st.age_tick = 1'b0;
      if (st_ff.age_cnt >= st_ff.age_period) begin
         nxt_st.age_cnt = 32'h0;
         nxt_st.age_tick = 1'b1;
      end else begin
         nxt_st.age_cnt = st_ff.age_cnt + 32'h1;
      end
      // verdict, registered one cycle after the header
      nxt_st.verd.valid = frame_in.valid;
      nxt_st.verd.drop_self = frame_in.valid && self_hit;
      nxt_st.verd.drop_dup = frame_in.valid && dup_hit;
      nxt_st.verd.egress = (frame_in.host_tagged && frame_in.valid) ? frame_in.tail_ports : '0;
      if (frame_in.valid && on_ring && frame_in.hsr) begin
         // lru names the way to replace next: the other one from the way just hit or filled
         if (hit0 || hit1) nxt_st.lru[set_idx] = hit0;
         else if (alloc) nxt_st.lru[set_idx] = !alloc_addr[0];
      end
   end

   // table write: new frames allocate, full sets replace the lru way
   always_comb begin
      alloc = frame_in.valid && frame_in.hsr && on_ring && st_ff.dup_ctrl[BIT_DUP_EN] && !(hit0 || hit1);
      if (!e0.valid) alloc_addr = {set_idx, 1'b0};
      else if (!e1.valid) alloc_addr = {set_idx, 1'b1};
      else alloc_addr = {set_idx, st_ff.lru[set_idx]};
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < DUP_ENTRIES; i++) dup_mem[i] <= '0;
      end else if (acc_wr) begin
         dup_mem[st_ff.dup_idx] <= rra_dup_entry_t'(st_ff.dup_data[$bits(rra_dup_entry_t)-1:0]);
      end else if (alloc) begin
         dup_mem[alloc_addr] <= '{valid: 1'b1, seq: frame_in.seq,
                                  port: NPORT'(1) << frame_in.port, age: '0};
      end else if (st_ff.age_tick) begin
         for (int i = 0; i < DUP_ENTRIES; i++) begin
            if (dup_mem[i].age == '1) dup_mem[i].valid <= 1'b0;
            else dup_mem[i].age <= dup_mem[i].age + AGE_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= '0;
         st_ff.bcn_window <= RST_BCN_WINDOW;
         st_ff.stp <= {NPORT{RST_STP}};
         st_ff.age_period <= 32'(AGE_PERIOD_DEF);
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flip-flops
   assign prdata = st_ff.rdata;
   assign pready = st_ff.ready;
   assign pslverr = st_ff.err;
   assign verdict = st_ff.verd;
   assign port_blocked = st_ff.blocked;
   assign flush_req = st_ff.flush;
   assign supervisor_lost = st_ff.sup_lost;

   // a frame seen on the other ring port with the same sequence is dropped next cycle
   sequence dup_seen_s;
      frame_in.valid && dup_hit;
   endsequence
   dup_drop_a: assert property (@(posedge clk) disable iff (srst) dup_seen_s |=> verdict.drop_dup)
      else $error("duplicate not dropped");
   dup_off_a: assert property (@(posedge clk) disable iff (srst)
      !st_ff.dup_ctrl[BIT_DUP_EN] |=> !verdict.drop_dup)
      else $error("discard active while disabled");
   self_filt_a: assert property (@(posedge clk) disable iff (srst)
      (frame_in.valid && frame_in.sa == st_ff.own_mac && st_ff.lue_ctrl1[BIT_SELF_FILT_ALL]) |=> verdict.drop_self)
      else $error("self frame forwarded");
   block_map_a: assert property (@(posedge clk) disable iff (srst)
      ##1 port_blocked == $past(nxt_st.blocked))
      else $error("block state mismatch");
   tail_egress_a: assert property (@(posedge clk) disable iff (srst)
      (frame_in.valid && frame_in.host_tagged) |=> verdict.egress == $past(frame_in.tail_ports))
      else $error("egress not from tail tag");
   sup_need_mode_a: assert property (@(posedge clk) disable iff (srst)
      $rose(supervisor_lost) |-> $past(st_ff.ring_ctrl[BIT_BACKUP_SUP]))
      else $error("loss outside backup mode");
   sup_window_a: assert property (@(posedge clk) disable iff (srst)
      $rose(supervisor_lost) |-> ($past(st_ff.bcn_gap) <= $past(st_ff.bcn_window) || !$past(st_ff.first_seen)))
      else $error("loss beyond window");
   flush_pulse_a: assert property (@(posedge clk) disable iff (srst) flush_req |=> !flush_req)
      else $error("flush longer than a cycle");
   lru_fill_a: assert property (@(posedge clk) disable iff (srst)
      (alloc && e0.valid && e1.valid) |-> alloc_addr[0] == st_ff.lru[set_idx])
      else $error("lru way not replaced");
   lru_flip_a: assert property (@(posedge clk) disable iff (srst)
      (alloc && e0.valid && e1.valid) |=> st_ff.lru[$past(set_idx)] != $past(st_ff.lru[set_idx]))
      else $error("lru not moved after replace");
   sup_pulse_a: assert property (@(posedge clk) disable iff (srst)
      $rose(supervisor_lost) |-> $past(|(acl_bcn_timeout & st_ff.dlr_ports)))
      else $error("loss without a ring timeout");
   hsr_map_a: assert property (@(posedge clk) disable iff (srst)
      !rra_two_bits(st_ff.hsr_ports) |=> !verdict.drop_dup)
      else $error("discard without a two-port map");
endmodule : rra_core

// file: sim/rra_ring_peer.sv
// rra_ring_peer: ring neighbours, host port and acl engine facing the assist block
// assumes the bench calls its tasks from its own thread; all drive is just after clk
module rra_ring_peer
   import rra_pkg::*;
(
   // clock
   input wire logic clk,
   // toward the block
   output rra_pkg::rra_frame_t frame_in,
   output logic [rra_pkg::NPORT-1:0] acl_bcn_timeout
);
   timeunit 1ns;
   timeprecision 100ps;

   // destination address of the flow; changing a single byte of it moves the flow to another table set
   logic [47:0] dest;

   initial begin
      frame_in = '0;
      acl_bcn_timeout = '0;
      dest = 48'h0115_4e00_0001;
   end

   task automatic set_dest(input logic [47:0] d);
      dest = d;
   endtask : set_dest

   // one header per call; host frames carry their own tag, sequence and tail ports
   task automatic send(input logic [2:0] port, input logic [47:0] sa, input logic [15:0] seq,
                       input logic hsr, input logic host, input logic [NPORT-1:0] tail);
      @(posedge clk);
      frame_in <= '{1'b1, port, sa, dest, hsr, seq, host, tail};
      @(posedge clk);
      // idle header is scrambled so nothing leans on stale fields
      frame_in <= {1'b0, ~frame_in[$bits(rra_frame_t)-2:0]};
   endtask : send

   // one-cycle beacon timeout pulse on the ports in mask
   task automatic beacon(input logic [NPORT-1:0] mask);
      @(posedge clk);
      acl_bcn_timeout <= mask;
      @(posedge clk);
      acl_bcn_timeout <= '0;
   endtask : beacon
endmodule : rra_ring_peer

// file: sim/tb_ring_redundancy_assist.sv
// tb_ring_redundancy_assist: self-checking bench for rra_core over apb and frame headers
// assumes the core answers apb with one wait state and verdicts one cycle after a header
module tb_ring_redundancy_assist
   import rra_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, srst, psel, penable, pwrite, pready, pslverr, flush_req, supervisor_lost;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [NPORT-1:0] acl_bcn_timeout, port_blocked;
   rra_frame_t frame_in;
   rra_verdict_t verdict;
   int num_errors, check_count, cycles, flush_seen;

   // short aging period keeps the aging test inside a few hundred cycles
   rra_core #(.AGE_PERIOD_DEF(16)) dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .acl_bcn_timeout(acl_bcn_timeout), .frame_in(frame_in), .verdict(verdict),
      .port_blocked(port_blocked), .flush_req(flush_req), .supervisor_lost(supervisor_lost));
   rra_ring_peer peer (.clk(clk), .frame_in(frame_in), .acl_bcn_timeout(acl_bcn_timeout));

   always #2 clk = ~clk;

   // hang guard and flush pulse counter
   always @(posedge clk) begin
      cycles++;
      if (flush_req === 1'b1) flush_seen++;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one apb transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(what, r, exp);
   endtask : rd_chk

   // verdict flags {valid, drop_self, drop_dup} right after the answering edge
   task automatic vchk(input string what, input logic [2:0] exp);
      #1;
      check(what, {29'h0, verdict.valid, verdict.drop_self, verdict.drop_dup}, {29'h0, exp});
   endtask : vchk

   task automatic t_regs;
      logic [31:0] r;
      logic e;
      rd_chk("window reset", ADDR_BCN_WINDOW, 32'h0);
      apb(1'b0, 12'h7fc, 32'h0, r, e);
      check("unmapped err", {31'h0, e}, 32'h1);
      wr(ADDR_BCN_WINDOW, 32'h5);
      rd_chk("window", ADDR_BCN_WINDOW, 32'h5);
      wr(ADDR_RING_CTRL, 32'h4);
      rd_chk("ring ctrl", ADDR_RING_CTRL, 32'h4);
      $display("test regs done");
   endtask : t_regs

   task automatic t_dlr;
      wr(ADDR_DLR_PORTS, 32'h3);
      peer.beacon(7'h01);
      repeat (3) @(posedge clk);
      peer.beacon(7'h02);
      repeat (2) @(posedge clk);
      check("lost inside window", {31'h0, supervisor_lost}, 32'h1);
      wr(ADDR_RING_STAT, 32'h1);
      repeat (2) @(posedge clk);
      check("lost cleared", {31'h0, supervisor_lost}, 32'h0);
      peer.beacon(7'h01);
      peer.beacon(7'h01);
      repeat (2) @(posedge clk);
      peer.beacon(7'h02);
      repeat (2) @(posedge clk);
      check("lost beyond window", {31'h0, supervisor_lost}, 32'h0);
      repeat (20) @(posedge clk);
      peer.beacon(7'h01);
      peer.beacon(7'h04);
      repeat (2) @(posedge clk);
      check("lost off map", {31'h0, supervisor_lost}, 32'h0);
      wr(ADDR_RING_CTRL, 32'h0);
      peer.beacon(7'h01);
      peer.beacon(7'h02);
      repeat (2) @(posedge clk);
      check("lost not backup", {31'h0, supervisor_lost}, 32'h0);
      $display("test dlr done");
   endtask : t_dlr

   task automatic t_block_flush;
      wr(ADDR_PORT_STP, 32'h0000_0200);
      repeat (2) @(posedge clk);
      check("blocked", {25'h0, port_blocked}, 32'h4);
      wr(ADDR_PORT_STP, 32'h0000_0202);
      repeat (2) @(posedge clk);
      check("one stp bit", {25'h0, port_blocked}, 32'h0);
      flush_seen = 0;
      wr(ADDR_LUE_CTRL2, 32'h1);
      repeat (4) @(posedge clk);
      check("flush pulses", flush_seen, 32'h1);
      $display("test block flush done");
   endtask : t_block_flush

   task automatic t_hsr;
      wr(ADDR_HSR_PORTS, 32'h3);
      wr(ADDR_DUP_CTRL, 32'h80);
      peer.send(3'd0, 48'h0a0b_0c0d_0e0f, 16'h5, 1'b1, 1'b0, 7'h0);
      vchk("first copy", 3'b100);
      peer.send(3'd1, 48'h0a0b_0c0d_0e0f, 16'h5, 1'b1, 1'b0, 7'h0);
      vchk("second copy", 3'b101);
      peer.send(3'd0, 48'h0a0b_0c0d_0e0f, 16'h6, 1'b1, 1'b0, 7'h0);
      repeat (200) @(posedge clk);
      peer.send(3'd1, 48'h0a0b_0c0d_0e0f, 16'h6, 1'b1, 1'b0, 7'h0);
      vchk("aged copy", 3'b100);
      peer.send(3'd0, 48'h0a0b_0c0d_0e0f, 16'h7, 1'b1, 1'b0, 7'h0);
      wr(ADDR_DUP_CTRL, 32'h0);
      peer.send(3'd1, 48'h0a0b_0c0d_0e0f, 16'h7, 1'b1, 1'b0, 7'h0);
      vchk("discard off", 3'b100);
      peer.send(3'd6, 48'h0a0b_0c0d_0e0f, 16'h8, 1'b1, 1'b1, 7'h14);
      #1;
      check("tail egress", {25'h0, verdict.egress}, 32'h14);
      $display("test hsr done");
   endtask : t_hsr

   // lru replacement in a full set, a second flow by da, and indirect table access
   task automatic t_table;
      wr(ADDR_DUP_CTRL, 32'h80);
      peer.set_dest(48'h0115_4e00_0002);
      peer.send(3'd0, 48'h0a0b_0c0d_0e0f, 16'h10, 1'b1, 1'b0, 7'h0);
      peer.send(3'd0, 48'h0a0b_0c0d_0e0f, 16'h11, 1'b1, 1'b0, 7'h0);
      peer.send(3'd0, 48'h0a0b_0c0d_0e0f, 16'h12, 1'b1, 1'b0, 7'h0);
      peer.send(3'd0, 48'h0a0b_0c0d_0e0f, 16'h13, 1'b1, 1'b0, 7'h0);
      vchk("fill set", 3'b100);
      peer.send(3'd1, 48'h0a0b_0c0d_0e0f, 16'h12, 1'b1, 1'b0, 7'h0);
      vchk("lru kept", 3'b101);
      peer.send(3'd1, 48'h0a0b_0c0d_0e0f, 16'h10, 1'b1, 1'b0, 7'h0);
      vchk("evicted dup passes", 3'b100);
      peer.set_dest(48'h0115_4e00_0003);
      peer.send(3'd0, 48'h0a0b_0c0d_0e0f, 16'h20, 1'b1, 1'b0, 7'h0);
      peer.set_dest(48'h0115_4e00_0002);
      peer.send(3'd1, 48'h0a0b_0c0d_0e0f, 16'h20, 1'b1, 1'b0, 7'h0);
      vchk("other da flow", 3'b100);
      // invalid entry with full age, so a sweep cannot alter it between write and read
      wr(ADDR_DUP_DATA, 32'h00b4_b457);
      wr(ADDR_DUP_IDX, 32'h0000_01ff);
      wr(ADDR_DUP_ACC, 32'h1);
      wr(ADDR_DUP_DATA, 32'h0);
      wr(ADDR_DUP_ACC, 32'h2);
      rd_chk("table word", ADDR_DUP_DATA, 32'h00b4_b457);
      $display("test table done");
   endtask : t_table

   task automatic t_self;
      wr(ADDR_OWN_MAC_LO, 32'h4433_2211);
      wr(ADDR_OWN_MAC_HI, 32'h0000_6655);
      wr(ADDR_LUE_CTRL1, 32'h40);
      peer.send(3'd3, 48'h6655_4433_2211, 16'h0, 1'b0, 1'b0, 7'h0);
      vchk("own sa global", 3'b110);
      peer.send(3'd3, 48'h6655_4433_2210, 16'h0, 1'b0, 1'b0, 7'h0);
      vchk("other sa", 3'b100);
      wr(ADDR_LUE_CTRL1, 32'h0);
      wr(ADDR_PORT_SAF, 32'h8);
      peer.send(3'd3, 48'h6655_4433_2211, 16'h0, 1'b0, 1'b0, 7'h0);
      vchk("own sa port on", 3'b110);
      peer.send(3'd4, 48'h6655_4433_2211, 16'h0, 1'b0, 1'b0, 7'h0);
      vchk("own sa port off", 3'b100);
      $display("test self done");
   endtask : t_self

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   initial begin
      {clk, psel, penable, pwrite, pwdata, paddr} = '0;
      srst = 1'b1;
      {num_errors, check_count, cycles, flush_seen} = '0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_dlr();
      t_block_flush();
      t_hsr();
      t_table();
      t_self();
      close_out();
   end
endmodule : tb_ring_redundancy_assist
